/* File: rtl/arop_defines.svh */
/*
 Constants for the result output port: widths, counts, field positions.
 Assumes inclusion by bare name from rtl/.
*/
`ifndef AROP_DEFINES_SVH
`define AROP_DEFINES_SVH
`define AROP_RES_W 18
`define AROP_CHANNELS 8
`define AROP_CH_W 3
`define AROP_FIFO_DEPTH 8
`define AROP_BUS_W 16
`define AROP_OS_W 3
`define AROP_OS_MSB 2
`define AROP_OS_LSB 0
`define AROP_IFSEL_PAR 1'h0
`define AROP_IFSEL_SER 1'h1
`define AROP_ZERO_BUS 16'h0000
`define AROP_ZERO_RES 18'h00000
`define AROP_MAX_POS 18'h1ffff
`define AROP_MAX_NEG 18'h20000
`endif

/* File: rtl/arop_pkg.sv */
/*
 Types shared by the result output port files.
 Assumes arop_defines.svh is on the include path.
*/
`include "arop_defines.svh"
package arop_pkg;
    typedef logic [`AROP_RES_W-1:0] arop_result_type;
    // One FIFO word: channel number and its conversion code
    typedef struct packed {
        logic [`AROP_CH_W-1:0] channel;
        arop_result_type code;
    } arop_word_type;
    typedef enum logic [7:0] {
        AROP_OSR_1 = 8'h01, AROP_OSR_2 = 8'h02, AROP_OSR_4 = 8'h04, AROP_OSR_8 = 8'h08,
        AROP_OSR_16 = 8'h10, AROP_OSR_32 = 8'h20, AROP_OSR_64 = 8'h40, AROP_OSR_INVALID = 8'h80
    } arop_osr_type;
    typedef enum logic [2:0] {
        AROP_IDLE = 3'h1, AROP_UPPER = 3'h2, AROP_LOWER = 3'h4
    } arop_state_type;
endpackage

/* File: rtl/arop_fifo.sv */
/*
 Parameterised synchronous FIFO with valid/ready on both sides.
 Assumes one clock, async active-low reset and a global clock enable.
*/
`include "arop_defines.svh"
module arop_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = `AROP_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_reg];
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    // Storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // Pointers wrap by index arithmetic, so depth need not be a power of two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        count_reg <= DEPTH) else $error("FIFO count above depth");
endmodule

/* File: rtl/arop_port.sv */
/*
 Result output port: conversion words pass a FIFO and leave on the
 16-bit parallel bus (two read strobes per channel) or two serial lines.
 Assumes host pins already synchronous to CLOCK; the core pushes words
 in channel order, one frame of all channels per conversion.
*/
// Overview of operation
// - Oversampling select decoded as binary ratio code, bit 2 most significant.
// - Bus line 15 gives result bit 17 first strobe, bit 1 second.
// - Bus line 14 gives result bit 16 first strobe, bit 0 second.
// - Lines 13..9 give bits 15..11 first strobe, zero on second.
// - Lines 6..0 give bits 8..2 first strobe, zero on second.
// - Lines 7 and 8 give bits 9 and 10 while select and strobe low.
// - Parallel mode bus driven only while chip select and read strobe low.
// - Serial mode drives data on lines 7, 8; host grounds the rest.
// - Results are two's complement, full scale 0111.. and 1000..
// - Sampling returns to tracking at each conversion end.
// - Two read strobes per channel, upper portion then lower.
// - Select fall shows MSB; each serial clock rise shifts next bit.
// - Interface select low means parallel, high means serial.
`include "arop_defines.svh"
module arop_port
    import arop_pkg::*;
#(
    parameter int RES_W = `AROP_RES_W,
    parameter int CHANNELS = `AROP_CHANNELS,
    parameter int FIFO_DEPTH = `AROP_FIFO_DEPTH
) (
    // Clock, reset, enable
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic CLOCK_EN,
    // Conversion core side
    input wire arop_word_type CONV_WORD,
    input wire logic CONV_VALID,
    output logic CONV_READY,
    input wire logic CONV_DONE,
    output logic TRACK,
    // Configuration straps
    input wire logic [`AROP_OS_W-1:0] OVERSAMPLE_RATIO_SEL,
    output arop_osr_type OVERSAMPLE_RATIO,
    input wire logic INTERFACE_SELECT,
    // Host pins
    input wire logic CS_N,
    input wire logic RD_SCLK,
    output logic [`AROP_BUS_W-1:0] PARALLEL_DATA_BUS,
    output logic [`AROP_BUS_W-1:0] PARALLEL_DATA_OE,
    output logic FIRST_CHANNEL
);
    arop_word_type fifo_word;
    logic fifo_valid;
    logic fifo_pop;
    logic fifo_in_ready;
    arop_state_type state_reg;
    arop_state_type state_next;
    arop_word_type cur_reg;
    logic [RES_W-1:0] shift_reg;
    logic cs_d_reg;
    logic rd_d_reg;
    logic cs_fall;
    logic cs_rise;
    logic rd_fall;
    logic rd_rise;
    logic rd_active;

    // Maps one code onto the bus for upper or lower half
    function automatic logic [`AROP_BUS_W-1:0] bus_map(input arop_result_type c, input logic lower);
        if (!lower) begin
            return {c[17], c[16], c[15:11], c[10], c[9], c[8:2]};
        end
        return {c[1], c[0], 5'h00, c[10], c[9], 7'h00};
    endfunction

    // Binary ratio decode of the three strap bits
    function automatic arop_osr_type os_decode(input logic [`AROP_OS_W-1:0] s);
        case (s)
            3'h0: return AROP_OSR_1;
            3'h1: return AROP_OSR_2;
            3'h2: return AROP_OSR_4;
            3'h3: return AROP_OSR_8;
            3'h4: return AROP_OSR_16;
            3'h5: return AROP_OSR_32;
            3'h6: return AROP_OSR_64;
            default: return AROP_OSR_INVALID;
        endcase
    endfunction

    arop_fifo #(
        .WIDTH($bits(arop_word_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLOCK),
        .rst_n(RESETN),
        .ce(CLOCK_EN),
        .in_data(CONV_WORD),
        .in_valid(CONV_VALID),
        .in_ready(fifo_in_ready),
        .out_data(fifo_word),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Strobe edges; pins are synchronous so one stage is enough
    assign cs_fall = cs_d_reg && !CS_N;
    assign cs_rise = !cs_d_reg && CS_N;
    assign rd_fall = rd_d_reg && !RD_SCLK;
    assign rd_rise = !rd_d_reg && RD_SCLK;
    assign rd_active = !CS_N && !RD_SCLK;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            cs_d_reg <= 1'b1;
            rd_d_reg <= 1'b1;
        end else if (CLOCK_EN) begin
            cs_d_reg <= CS_N;
            rd_d_reg <= RD_SCLK;
        end
    end

    // Sequencer: a word is popped when its transfer begins
    always_comb begin
        state_next = state_reg;
        fifo_pop = 1'b0;
        case (state_reg)
            AROP_IDLE: begin
                if (INTERFACE_SELECT == `AROP_IFSEL_PAR) begin
                    if (rd_fall && !CS_N && fifo_valid) begin
                        fifo_pop = 1'b1;
                        state_next = AROP_UPPER;
                    end
                end else if (cs_fall && fifo_valid) begin
                    fifo_pop = 1'b1;
                    state_next = AROP_UPPER;
                end
            end
            AROP_UPPER: begin
                if (INTERFACE_SELECT == `AROP_IFSEL_SER) begin
                    if (cs_rise) begin
                        state_next = AROP_IDLE;
                    end
                end else if (rd_fall && !CS_N) begin
                    state_next = AROP_LOWER;
                end
            end
            AROP_LOWER: begin
                if (rd_rise || CS_N) begin
                    state_next = AROP_IDLE;
                end
            end
            default: state_next = AROP_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= AROP_IDLE;
        end else if (CLOCK_EN) begin
            state_reg <= state_next;
        end
    end

    // Current word and serial shifter; code is two's complement as given
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            cur_reg <= '0;
            shift_reg <= `AROP_ZERO_RES;
        end else if (CLOCK_EN) begin
            if (fifo_pop) begin
                cur_reg <= fifo_word;
                shift_reg <= fifo_word.code;
            end else if (state_reg == AROP_UPPER && INTERFACE_SELECT && rd_rise) begin
                shift_reg <= {shift_reg[RES_W-2:0], 1'b0};
            end
        end
    end

    // Pin drivers, all registered; bus driven only during a valid read
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            PARALLEL_DATA_BUS <= `AROP_ZERO_BUS;
            PARALLEL_DATA_OE <= `AROP_ZERO_BUS;
            FIRST_CHANNEL <= 1'b0;
        end else if (CLOCK_EN) begin
            PARALLEL_DATA_BUS <= `AROP_ZERO_BUS;
            PARALLEL_DATA_OE <= `AROP_ZERO_BUS;
            if (INTERFACE_SELECT == `AROP_IFSEL_SER) begin
                // Only lines 7 and 8 leave the device; the rest are grounded outside
                if (state_next == AROP_UPPER) begin
                    PARALLEL_DATA_BUS[7] <= fifo_pop ? fifo_word.code[RES_W-1] : state_next == state_reg &&
                        rd_rise ? shift_reg[RES_W-2] : shift_reg[RES_W-1];
                    PARALLEL_DATA_BUS[8] <= fifo_pop ? fifo_word.code[RES_W-1] : state_next == state_reg &&
                        rd_rise ? shift_reg[RES_W-2] : shift_reg[RES_W-1];
                    PARALLEL_DATA_OE[8:7] <= 2'h3;
                end
            end else if (rd_active && state_next != AROP_IDLE) begin
                PARALLEL_DATA_BUS <= bus_map(fifo_pop ? fifo_word.code : cur_reg.code,
                    state_next == AROP_LOWER);
                PARALLEL_DATA_OE <= 16'hffff;
            end
            if (CS_N) begin
                FIRST_CHANNEL <= 1'b0;
            end else if (fifo_pop) begin
                FIRST_CHANNEL <= (fifo_word.channel == '0);
            end
        end
    end

    // Ratio decode, core back-pressure and tracking flag
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            OVERSAMPLE_RATIO <= AROP_OSR_1;
            CONV_READY <= 1'b0;
            TRACK <= 1'b1;
        end else if (CLOCK_EN) begin
            OVERSAMPLE_RATIO <= os_decode(OVERSAMPLE_RATIO_SEL);
            CONV_READY <= fifo_in_ready;
            if (CONV_DONE) begin
                TRACK <= 1'b1;
            end else if (CONV_VALID) begin
                TRACK <= 1'b0;
            end
        end
    end

    a_par_oe_gate: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (PARALLEL_DATA_OE == 16'hffff) |-> $past(rd_active) && !$past(INTERFACE_SELECT))
        else $error("Bus driven outside a read");
    a_lower_zeros: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (state_reg == AROP_LOWER && PARALLEL_DATA_OE[0]) |->
        PARALLEL_DATA_BUS[13:9] == 5'h00 && PARALLEL_DATA_BUS[6:0] == 7'h00)
        else $error("Lower half not zero");
    a_lower_bits: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (state_reg == AROP_LOWER && PARALLEL_DATA_OE[15] && $past(state_reg) == AROP_LOWER) |->
        PARALLEL_DATA_BUS[15:14] == cur_reg.code[1:0]) else $error("Lower bits wrong");
    a_upper_bits: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (state_reg == AROP_UPPER && PARALLEL_DATA_OE[15] && $past(state_reg) == AROP_UPPER) |->
        PARALLEL_DATA_BUS == {cur_reg.code[17:11], cur_reg.code[10:9], cur_reg.code[8:2]})
        else $error("Upper half wrong");
    a_serial_lines: assert property (@(posedge CLOCK) disable iff (!RESETN)
        INTERFACE_SELECT && $past(INTERFACE_SELECT) |-> PARALLEL_DATA_OE[15:9] == 7'h00 &&
        PARALLEL_DATA_OE[6:0] == 7'h00) else $error("Serial mode drives spare lines");
    a_osr_decode: assert property (@(posedge CLOCK) disable iff (!RESETN)
        CLOCK_EN && OVERSAMPLE_RATIO_SEL == 3'h4 |=> OVERSAMPLE_RATIO == AROP_OSR_16)
        else $error("Ratio decode wrong");
    a_track_on_done: assert property (@(posedge CLOCK) disable iff (!RESETN)
        CLOCK_EN && CONV_DONE |=> TRACK) else $error("No tracking after conversion");
    a_two_strobes: assert property (@(posedge CLOCK) disable iff (!RESETN)
        state_reg == AROP_LOWER |-> $past(state_reg) != AROP_IDLE)
        else $error("Lower half without upper");
    a_serial_msb: assert property (@(posedge CLOCK) disable iff (!RESETN)
        CLOCK_EN && INTERFACE_SELECT && fifo_pop |=> PARALLEL_DATA_BUS[7] == cur_reg.code[17])
        else $error("Serial MSB missing");
    c_par_read: cover property (@(posedge CLOCK) disable iff (!RESETN)
        state_reg == AROP_UPPER ##[1:40] state_reg == AROP_LOWER);
    c_ser_frame: cover property (@(posedge CLOCK) disable iff (!RESETN)
        INTERFACE_SELECT && state_reg == AROP_UPPER ##[1:100] state_reg == AROP_IDLE);
    c_fifo_full: cover property (@(posedge CLOCK) disable iff (!RESETN) !CONV_READY && RESETN);
endmodule

/* File: test/arop_host_model.sv */
/*
 Host controller model: drives chip select and read strobe / serial clock.
 Assumes the bench shares the clock and calls the tasks from its thread.
*/
module arop_host_model (
    // Clock
    input wire logic clk,
    // Host pins
    output logic cs_n,
    output logic rd_sclk,
    input wire logic [15:0] bus,
    input wire logic [15:0] oe,
    input wire logic first
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle host: deselected, strobe high
    initial begin
        cs_n = 1'h1;
        rd_sclk = 1'h1;
    end
    // Undriven lines float, so a stale value never passes
    function automatic logic [15:0] pins();
        for (int i = 0; i < 16; i++) begin
            pins[i] = oe[i] ? bus[i] : 1'bz;
        end
    endfunction
    // One strobe: low two cycles, then high two cycles
    task automatic strobe(output logic [15:0] word);
        @(negedge clk);
        cs_n = 1'h0;
        rd_sclk = 1'h0;
        repeat (2) @(negedge clk);
        word = pins();
        // Deselect with the strobe so a later serial frame sees a select fall
        rd_sclk = 1'h1;
        cs_n = 1'h1;
        repeat (2) @(negedge clk);
    endtask
    // Two strobes per channel, upper portion first
    task automatic par_read(output logic [15:0] up, output logic [15:0] lo);
        strobe(up);
        strobe(lo);
    endtask
    // Serial frame: 18 clock rises, then deselect
    task automatic ser_read(output logic [17:0] wa, output logic [17:0] wb, output logic [16:0] snap);
        logic [15:0] p;
        @(negedge clk);
        cs_n = 1'h0;
        repeat (2) @(negedge clk);
        snap = {first, oe};
        for (int i = 17; i >= 0; i--) begin
            p = pins();
            wa[i] = p[7]; // Only lines 7 and 8; the rest are grounded
            wb[i] = p[8];
            rd_sclk = 1'h0;
            @(negedge clk);
            rd_sclk = 1'h1;
            repeat (2) @(negedge clk);
        end
        cs_n = 1'h1;
        repeat (2) @(negedge clk);
    endtask
endmodule

/* File: test/arop_port_tb.sv */
/*
 Self-checking bench for the result output port.
 Assumes the package and defines header are compiled first.
*/
`include "arop_defines.svh"
module arop_port_tb import arop_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0;
    logic resetn, clock_en, conv_valid, conv_done, conv_ready, track, interface_select;
    logic cs_n, rd_sclk, first_channel;
    logic [2:0] osr_sel;
    logic [15:0] bus, oe;
    arop_word_type conv_word;
    arop_osr_type osr;
    int err_total = 0;
    int n_checks = 0;
    arop_result_type codes [8] = '{18'h1ffff, 18'h20000, 18'h2aaaa, 18'h15555,
                                   18'h00001, 18'h3ffff, 18'h00000, 18'h12345};
    // 25 MHz clock
    always #20 clock = ~clock;
    arop_port dut_u (.CLOCK(clock), .RESETN(resetn), .CLOCK_EN(clock_en), .CONV_WORD(conv_word),
        .CONV_VALID(conv_valid), .CONV_READY(conv_ready), .CONV_DONE(conv_done), .TRACK(track),
        .OVERSAMPLE_RATIO_SEL(osr_sel), .OVERSAMPLE_RATIO(osr), .INTERFACE_SELECT(interface_select),
        .CS_N(cs_n), .RD_SCLK(rd_sclk), .PARALLEL_DATA_BUS(bus), .PARALLEL_DATA_OE(oe),
        .FIRST_CHANNEL(first_channel));
    arop_host_model host_u (.clk(clock), .cs_n(cs_n), .rd_sclk(rd_sclk), .bus(bus), .oe(oe),
        .first(first_channel));
    // Single compare point for all scenarios
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Second strobe layout, worked out independently of the design
    function automatic logic [15:0] low_of(arop_result_type c);
        return {c[1:0], 5'h00, c[10:9], 7'h00};
    endfunction
    // Eight words back to back, then end of conversion
    task automatic push_frame();
        conv_valid = 1'h1;
        for (int ch = 0; ch < 8; ch++) begin
            conv_word = '{channel: ch[2:0], code: codes[ch]};
            @(negedge clock);
        end
        conv_valid = 1'h0;
        check(track, 1'h0, "track held");
        conv_done = 1'h1;
        @(negedge clock);
        conv_done = 1'h0;
        @(negedge clock);
        check(track, 1'h1, "track resumed");
    endtask
    task automatic t_ratio();
        for (int s = 0; s < 8; s++) begin
            osr_sel = s[2:0];
            repeat (2) @(negedge clock);
            check(osr, 8'h01 << s, "ratio");
        end
        // Enable low must freeze the decoded ratio
        clock_en = 1'h0;
        osr_sel = 3'h0;
        repeat (2) @(negedge clock);
        check(osr, 8'h80, "frozen ratio");
        clock_en = 1'h1;
        repeat (2) @(negedge clock);
        check(osr, 8'h01, "ratio resumed");
    endtask
    task automatic t_parallel();
        logic [15:0] up, lo;
        interface_select = `AROP_IFSEL_PAR;
        push_frame();
        for (int ch = 0; ch < 8; ch++) begin
            host_u.par_read(up, lo);
            check(up, codes[ch][17:2], "upper");
            check(lo, low_of(codes[ch]), "lower");
            check(oe, 16'h0000, "released");
        end
        host_u.strobe(up);
        check(up, 16'hzzzz, "empty strobe");
    endtask
    // Fill until refused while host stalls, then drain serially
    task automatic t_serial();
        logic [17:0] wa, wb;
        logic [16:0] snap;
        interface_select = `AROP_IFSEL_SER;
        push_frame();
        check(conv_ready, 1'h0, "full");
        conv_word = '{channel: 3'h0, code: 18'h3c3c3};
        conv_valid = 1'h1;
        repeat (2) @(negedge clock);
        conv_valid = 1'h0;
        for (int ch = 0; ch < 8; ch++) begin
            host_u.ser_read(wa, wb, snap);
            check(wa, codes[ch], "line a");
            check(wb, codes[ch], "line b");
            check(snap, {ch == 0, 16'h0180}, "serial drive");
            check(first_channel, 1'h0, "first idle");
        end
        check(conv_ready, 1'h1, "drained");
        host_u.ser_read(wa, wb, snap);
        check(snap[15:0], 16'h0000, "empty frame");
    endtask
    // Hang guard, well past the expected run length
    initial begin
        #(40 * 20000);
        err_total++;
        tally_and_finish();
    end
    initial begin
        resetn = 1'h0;
        clock_en = 1'h1;
        conv_valid = 1'h0;
        conv_done = 1'h0;
        conv_word = '0;
        osr_sel = 3'h0;
        interface_select = `AROP_IFSEL_PAR;
        repeat (12) @(negedge clock);
        check({oe, bus}, 32'h0, "reset bus");
        check({first_channel, conv_ready}, 2'h0, "reset pins");
        check({track, osr}, {1'h1, AROP_OSR_1}, "reset state");
        resetn = 1'h1;
        repeat (3) @(negedge clock);
        t_ratio();
        t_parallel();
        t_serial();
        tally_and_finish();
    end
endmodule
